// >>> hdl/usb0c_ep0.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module usb0c_ep0
	import usb0c_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rstn_in,
	// axi4-lite register bus
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [USB0C_AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [USB0C_AW-1:0] s_axi_araddr_in,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	// serial engine side
	input wire usb0c_sie_s sie_ev_in,
	output logic hs_valid_out,
	output usb0c_hs_e hs_out,
	// interrupt
	output logic irq_out
);

	usb0c_wr_s wr;
	logic [USB0C_AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic [USB0C_EV_W-1:0] ev;
	logic [USB0C_EV_W-1:0] ist;
	logic [USB0C_EV_W-1:0] imsk;
	logic csr_wr;
	logic [7:0] wb;
	logic rx_waiting_r;
	logic tx_loaded_r;
	logic stall_sent_r;
	logic transfer_last_flag_r;
	logic early_ctrl_end_flag_r;
	logic force_stall_r;
	usb0c_mode_e mode_r;
	logic early_end_ev;
	logic rx_ev;
	logic tx_clr_ev;

	// ==========================================================
	// bus slave and interrupt block
	usb0c_axil u_axil (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awready_out(s_axi_awready_out),
		.s_axi_awaddr_in(s_axi_awaddr_in),
		.s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wready_out(s_axi_wready_out),
		.s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wstrb_in(s_axi_wstrb_in),
		.s_axi_bvalid_out(s_axi_bvalid_out),
		.s_axi_bready_in(s_axi_bready_in),
		.s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_arready_out(s_axi_arready_out),
		.s_axi_araddr_in(s_axi_araddr_in),
		.s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rready_in(s_axi_rready_in),
		.s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out),
		.wr_out(wr),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data)
	);

	usb0c_irq #(.EV_W(USB0C_EV_W)) u_irq (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.ev_in(ev),
		.st_wr_in(wr.en && wr.strb[0] &&
			usb0c_decode(wr.addr) == USB0C_REG_IST),
		.msk_wr_in(wr.en && wr.strb[0] &&
			usb0c_decode(wr.addr) == USB0C_REG_IMSK),
		.wdata_in(wr.data[USB0C_EV_W-1:0]),
		.status_out(ist),
		.mask_out(imsk),
		.irq_out(irq_out)
	);

	// ==========================================================
	// control register write decode, low byte lane only
	assign csr_wr = wr.en && wr.strb[0] &&
		usb0c_decode(wr.addr) == USB0C_REG_CSR;
	assign wb = csr_wr ? wr.data[7:0] : 8'h00; // zeros do nothing here; a zero in bit 2 still clears stall sent

	// early end: a token of the other kind, or a new setup, while
	// a data phase is open and firmware has not marked its end
	assign early_end_ev = !transfer_last_flag_r && (
		(sie_ev_in.setup_tok && mode_r != USB0C_MODE_IDLE) ||
		(sie_ev_in.in_tok && mode_r == USB0C_MODE_RX) ||
		(sie_ev_in.out_tok && mode_r == USB0C_MODE_TX));
	assign rx_ev = sie_ev_in.setup_rx || sie_ev_in.out_rx;
	// an arriving packet overwrites whatever IN data was loaded
	assign tx_clr_ev = sie_ev_in.in_sent || (rx_ev && tx_loaded_r);

	// interrupt events
	always_comb begin
		ev = '0;
		ev[USB0C_EV_RX] = rx_ev;
		ev[USB0C_EV_TX] = tx_clr_ev;
		ev[USB0C_EV_STALL] = sie_ev_in.stall_sent;
		ev[USB0C_EV_EEND] = early_end_ev;
		ev[USB0C_EV_STATUS] = sie_ev_in.status_done;
	end

	// ==========================================================
	// read mux; acknowledge and release bits read as zero
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (usb0c_decode(rd_addr))
			USB0C_REG_CSR: begin
				rd_data[USB0C_B_EEACK] = 1'b0;
				rd_data[USB0C_B_FSTALL] = force_stall_r;
				rd_data[USB0C_B_EEND] = early_ctrl_end_flag_r;
				rd_data[USB0C_B_LAST] = transfer_last_flag_r;
				rd_data[USB0C_B_SSENT] = stall_sent_r;
				rd_data[USB0C_B_TXLD] = tx_loaded_r;
				rd_data[USB0C_B_RXW] = rx_waiting_r;
			end
			USB0C_REG_IST: rd_data[USB0C_EV_W-1:0] = ist;
			USB0C_REG_IMSK: rd_data[USB0C_EV_W-1:0] = imsk;
			USB0C_REG_NONE: rd_data = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// received packet waiting; a new packet wins over release
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_waiting_r <= USB0C_CSR_RST[USB0C_B_RXW];
		end else if (rx_ev) begin
			rx_waiting_r <= 1'b1;
		end else if (wb[USB0C_B_RXREL]) begin
			rx_waiting_r <= 1'b0;
		end
	end

	// IN packet loaded; firmware reload in the same cycle wins
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_loaded_r <= USB0C_CSR_RST[USB0C_B_TXLD];
		end else if (wb[USB0C_B_TXLD]) begin
			tx_loaded_r <= 1'b1;
		end else if (tx_clr_ev) begin
			tx_loaded_r <= 1'b0;
		end
	end

	// forced stall holds until the engine reports it was sent
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			force_stall_r <= USB0C_CSR_RST[USB0C_B_FSTALL];
		end else if (wb[USB0C_B_FSTALL]) begin
			force_stall_r <= 1'b1;
		end else if (sie_ev_in.stall_sent) begin
			force_stall_r <= 1'b0;
		end
	end

	// stall sent; hardware only ever sets it, firmware writes 0
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stall_sent_r <= USB0C_CSR_RST[USB0C_B_SSENT];
		end else if (sie_ev_in.stall_sent) begin
			stall_sent_r <= 1'b1;
		end else if (csr_wr && !wr.data[USB0C_B_SSENT]) begin
			stall_sent_r <= 1'b0;
		end
	end

	// transfer last, set by firmware with its final packet
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			transfer_last_flag_r <= USB0C_CSR_RST[USB0C_B_LAST];
		end else if (wb[USB0C_B_LAST]) begin
			transfer_last_flag_r <= 1'b1;
		end else if (sie_ev_in.status_done || sie_ev_in.setup_tok) begin
			transfer_last_flag_r <= 1'b0;
		end
	end

	// early control end, event wins over acknowledge
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			early_ctrl_end_flag_r <= USB0C_CSR_RST[USB0C_B_EEND];
		end else if (early_end_ev) begin
			early_ctrl_end_flag_r <= 1'b1;
		end else if (wb[USB0C_B_EEACK]) begin
			early_ctrl_end_flag_r <= 1'b0;
		end
	end

	// ==========================================================
	// data phase direction; a setup always restarts the transfer
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_r <= USB0C_MODE_IDLE;
		end else if (sie_ev_in.setup_tok || sie_ev_in.status_done) begin
			mode_r <= USB0C_MODE_IDLE;
		end else if (sie_ev_in.in_tok && mode_r == USB0C_MODE_IDLE) begin
			mode_r <= USB0C_MODE_TX;
		end else if (sie_ev_in.out_tok && mode_r == USB0C_MODE_IDLE) begin
			mode_r <= USB0C_MODE_RX;
		end
	end

	// ==========================================================
	// handshake choice per token, registered for the engine
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hs_valid_out <= 1'b0;
			hs_out <= USB0C_HS_ACK;
		end else begin
			hs_valid_out <= sie_ev_in.setup_tok || sie_ev_in.in_tok ||
				sie_ev_in.out_tok;
			if (sie_ev_in.setup_tok) begin
				hs_out <= USB0C_HS_ACK; // setup is never refused
			end else if (sie_ev_in.in_tok) begin
				if (force_stall_r) begin
					hs_out <= USB0C_HS_STALL;
				end else if (transfer_last_flag_r && !tx_loaded_r &&
					mode_r == USB0C_MODE_TX) begin
					hs_out <= USB0C_HS_STALL;
				end else if (!tx_loaded_r) begin
					hs_out <= USB0C_HS_NAK;
				end else begin
					hs_out <= USB0C_HS_SEND;
				end
			end else if (sie_ev_in.out_tok) begin
				if (force_stall_r) begin
					hs_out <= USB0C_HS_STALL;
				end else if (transfer_last_flag_r &&
					mode_r == USB0C_MODE_RX) begin
					hs_out <= USB0C_HS_STALL;
				end else if (rx_waiting_r) begin
					hs_out <= USB0C_HS_NAK; // FIFO still owned by firmware
				end else begin
					hs_out <= USB0C_HS_ACK;
				end
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	chk_ack_reads_zero: assert property (
		s_axi_rvalid_out |-> !s_axi_rdata_out[USB0C_B_EEACK])
		else $error("early end acknowledge read back as one");
	chk_ack_clears_end: assert property (
		wb[USB0C_B_EEACK] && !early_end_ev |=> !early_ctrl_end_flag_r)
		else $error("acknowledge left early end set");
	chk_release_clears: assert property (
		wb[USB0C_B_RXREL] && !rx_ev |=> !rx_waiting_r)
		else $error("release left rx waiting set");
	chk_stall_answer: assert property (
		force_stall_r && (sie_ev_in.in_tok || sie_ev_in.out_tok) |=>
		hs_valid_out && hs_out == USB0C_HS_STALL)
		else $error("forced stall not answered with STALL");
	chk_stall_autoclr: assert property (
		sie_ev_in.stall_sent && !wb[USB0C_B_FSTALL] |=> !force_stall_r)
		else $error("force stall survived STALL sent");
	chk_early_end_set: assert property (
		sie_ev_in.setup_tok && mode_r != USB0C_MODE_IDLE &&
		!transfer_last_flag_r |=> early_ctrl_end_flag_r ##1 ist[USB0C_EV_EEND])
		else $error("early end not flagged");
	chk_last_autoclr: assert property (
		sie_ev_in.status_done && !wb[USB0C_B_LAST] |=> !transfer_last_flag_r)
		else $error("transfer last not cleared");
	chk_stall_flag_set: assert property (
		sie_ev_in.stall_sent |=> stall_sent_r)
		else $error("stall sent flag not set");
	chk_stall_flag_kept: assert property (
		stall_sent_r && !csr_wr |=> stall_sent_r)
		else $error("stall sent cleared without firmware");
	chk_tx_done_clear: assert property (
		sie_ev_in.in_sent && !wb[USB0C_B_TXLD] |=>
		!tx_loaded_r && ist[USB0C_EV_TX])
		else $error("IN sent did not clear and interrupt");
	chk_overwrite_clear: assert property (
		rx_ev && tx_loaded_r && !wb[USB0C_B_TXLD] |=> !tx_loaded_r)
		else $error("overwritten IN packet still loaded");
	chk_rx_set_irq: assert property (
		rx_ev |=> rx_waiting_r && ist[USB0C_EV_RX] ##1
		irq_out || !$past(imsk[USB0C_EV_RX]))
		else $error("received packet not flagged");
	chk_nak_when_empty: assert property (
		sie_ev_in.in_tok && !tx_loaded_r && !force_stall_r &&
		!transfer_last_flag_r |=> hs_out == USB0C_HS_NAK)
		else $error("IN with nothing loaded not NAKed");
	chk_out_after_last: assert property (
		sie_ev_in.out_tok && transfer_last_flag_r && mode_r == USB0C_MODE_RX
		|=> hs_out == USB0C_HS_STALL)
		else $error("OUT after transfer last not stalled");
	chk_zero_write_inert: assert property (
		csr_wr && wr.data[7:3] == 5'h00 && !sie_ev_in.stall_sent &&
		!early_end_ev && !sie_ev_in.status_done && !sie_ev_in.setup_tok
		|=> $stable(force_stall_r) && $stable(transfer_last_flag_r))
		else $error("zero write changed a flag");

	cov_out_stall: cover property (sie_ev_in.out_tok && force_stall_r);
	cov_early_end: cover property (early_end_ev ##[1:80] wb[USB0C_B_EEACK]);
	cov_in_sent: cover property (wb[USB0C_B_TXLD] ##[1:50] sie_ev_in.in_sent);
	cov_irq_rise: cover property ($rose(irq_out));

endmodule // usb0c_ep0

// >>> hdl/usb0c_pkg.sv
// How it works
// - writing one to bit 7 clears early end
// - early end acknowledge bit always reads zero
// - writing one to bit 6 clears rx waiting
// - writing one to bit 5 forces STALL answers
// - force stall clears once STALL was sent
// - early end set on premature transaction end
// - transfer last clears when transfer concludes
// - stall sent flag set after any STALL
// - only firmware clears the stall sent flag
// - IN sent clears tx loaded, raises interrupt
// - overwritten IN packet clears tx loaded, interrupts
// - received packet sets rx waiting, interrupts
// - control register at index 0x11, resets zero
// - OUT after transfer last gets STALL in receive mode
// - IN answered with NAK while nothing loaded, STALL instead once transfer last is set in transmit mode
package usb0c_pkg;

	// ==========================================================
	// register map
	localparam int USB0C_AW = 12;
	localparam logic [9:0] USB0C_CSR_IDX = 10'h011;
	localparam logic [9:0] USB0C_IST_IDX = 10'h020;
	localparam logic [9:0] USB0C_IMSK_IDX = 10'h021;
	localparam logic [7:0] USB0C_CSR_RST = 8'h00;
	localparam logic [4:0] USB0C_IRQ_RST = 5'h00;
	localparam logic [1:0] USB0C_RESP_OK = 2'h0;
	localparam logic [1:0] USB0C_RESP_ERR = 2'h2;

	// ==========================================================
	// control register field positions
	localparam int USB0C_B_EEACK = 7;
	localparam int USB0C_B_RXREL = 6;
	localparam int USB0C_B_FSTALL = 5;
	localparam int USB0C_B_EEND = 4;
	localparam int USB0C_B_LAST = 3;
	localparam int USB0C_B_SSENT = 2;
	localparam int USB0C_B_TXLD = 1;
	localparam int USB0C_B_RXW = 0;

	// ==========================================================
	// interrupt event positions
	localparam int USB0C_EV_RX = 0;
	localparam int USB0C_EV_TX = 1;
	localparam int USB0C_EV_STALL = 2;
	localparam int USB0C_EV_EEND = 3;
	localparam int USB0C_EV_STATUS = 4;
	localparam int USB0C_EV_W = 5;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		USB0C_REG_NONE = 2'b00,
		USB0C_REG_CSR = 2'b01,
		USB0C_REG_IST = 2'b10,
		USB0C_REG_IMSK = 2'b11
	} usb0c_reg_e;

	typedef enum logic [1:0] {
		USB0C_MODE_IDLE = 2'b00,
		USB0C_MODE_TX = 2'b01,
		USB0C_MODE_RX = 2'b10
	} usb0c_mode_e;

	typedef enum logic [1:0] {
		USB0C_HS_ACK = 2'b00,
		USB0C_HS_NAK = 2'b01,
		USB0C_HS_STALL = 2'b10,
		USB0C_HS_SEND = 2'b11
	} usb0c_hs_e;

	// one-cycle event pulses from the serial engine, same clock
	typedef struct packed {
		logic setup_tok;
		logic in_tok;
		logic out_tok;
		logic setup_rx;
		logic out_rx;
		logic in_sent;
		logic stall_sent;
		logic status_done;
	} usb0c_sie_s;

	// register write issued by the bus slave
	typedef struct packed {
		logic en;
		logic [USB0C_AW-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} usb0c_wr_s;

	// ==========================================================
	// word address decode, low two address bits ignored
	function automatic usb0c_reg_e usb0c_decode(
		input logic [USB0C_AW-1:0] a);
		logic [9:0] idx;
		idx = a[USB0C_AW-1:2];
		if (idx == USB0C_CSR_IDX) begin
			return USB0C_REG_CSR;
		end else if (idx == USB0C_IST_IDX) begin
			return USB0C_REG_IST;
		end else if (idx == USB0C_IMSK_IDX) begin
			return USB0C_REG_IMSK;
		end
		return USB0C_REG_NONE;
	endfunction

endpackage

// >>> hdl/usb0c_axil.sv
`timescale 1ns/100ps
module usb0c_axil
	import usb0c_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rstn_in,
	// write channels
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [USB0C_AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	// read channels
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [USB0C_AW-1:0] s_axi_araddr_in,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	// register side
	output usb0c_wr_s wr_out,
	output logic [USB0C_AW-1:0] rd_addr_out,
	input wire logic [31:0] rd_data_in
);

	logic aw_full_r;
	logic w_full_r;
	logic ar_full_r;
	logic [USB0C_AW-1:0] aw_addr_r;
	logic [USB0C_AW-1:0] rd_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;

	// readies are flops of their own, kept as the holding slots' inverse
	assign rd_addr_out = rd_addr_r;
	assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid_out;

	// ==========================================================
	// write address and data, taken in either order
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			aw_addr_r <= '0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid_in && !aw_full_r) begin
				aw_full_r <= 1'b1;
				s_axi_awready_out <= 1'b0;
				aw_addr_r <= s_axi_awaddr_in;
			end else if (wr_go) begin
				aw_full_r <= 1'b0;
				s_axi_awready_out <= 1'b1;
			end
			if (s_axi_wvalid_in && !w_full_r) begin
				w_full_r <= 1'b1;
				s_axi_wready_out <= 1'b0;
				w_data_r <= s_axi_wdata_in;
				w_strb_r <= s_axi_wstrb_in;
			end else if (wr_go) begin
				w_full_r <= 1'b0;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	// ==========================================================
	// write strobe to the registers and the response
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_out <= '0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= USB0C_RESP_OK;
		end else begin
			wr_out.en <= wr_go;
			wr_out.addr <= aw_addr_r;
			wr_out.data <= w_data_r;
			wr_out.strb <= w_strb_r;
			if (wr_go) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= usb0c_decode(aw_addr_r) == USB0C_REG_NONE
					? USB0C_RESP_ERR : USB0C_RESP_OK;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// ==========================================================
	// reads have no side effects, so data is sampled a cycle late
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ar_full_r <= 1'b0;
			s_axi_arready_out <= 1'b1;
			rd_addr_r <= '0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= USB0C_RESP_OK;
		end else begin
			if (s_axi_arvalid_in && !ar_full_r) begin
				ar_full_r <= 1'b1;
				s_axi_arready_out <= 1'b0;
				rd_addr_r <= s_axi_araddr_in;
			end else if (ar_full_r && !s_axi_rvalid_out) begin
				ar_full_r <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end
			// a pending answer leaves only on its own handshake
			if (ar_full_r && !s_axi_rvalid_out) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_data_in;
				s_axi_rresp_out <= usb0c_decode(rd_addr_r) == USB0C_REG_NONE
					? USB0C_RESP_ERR : USB0C_RESP_OK;
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

endmodule // usb0c_axil

// >>> hdl/usb0c_irq.sv
`timescale 1ns/100ps
module usb0c_irq
	import usb0c_pkg::*;
#(
	parameter int EV_W = USB0C_EV_W
)
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rstn_in,
	// events and software access
	input wire logic [EV_W-1:0] ev_in,
	input wire logic st_wr_in,
	input wire logic msk_wr_in,
	input wire logic [EV_W-1:0] wdata_in,
	// state
	output logic [EV_W-1:0] status_out,
	output logic [EV_W-1:0] mask_out,
	output logic irq_out
);

	// status and mask share one 8 bit byte lane
	if (EV_W < 1 || EV_W > 8) begin : g_bad_width
		$error("usb0c_irq: EV_W must be 1 to 8");
	end

	// ==========================================================
	// sticky status, write one to clear; a new event wins
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_out <= EV_W'(USB0C_IRQ_RST);
		end else begin
			status_out <= (status_out & ~(st_wr_in ? wdata_in : '0)) | ev_in;
		end
	end

	// ==========================================================
	// mask, one enables the bit onto the line
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mask_out <= EV_W'(USB0C_IRQ_RST);
		end else if (msk_wr_in) begin
			mask_out <= wdata_in;
		end
	end

	// level line, one cycle behind the status it reflects
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status_out & mask_out);
		end
	end

endmodule // usb0c_irq

// >>> testbench/usb0c_host.sv
`timescale 1ns/100ps
// ==========================================================
// host side: replays requested engine events, echoes STALLs
module usb0c_host
	import usb0c_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rstn_in,
	// requests and handshake decisions
	input wire logic [7:0] req_in,
	input wire logic hs_valid_in,
	input wire usb0c_hs_e hs_in,
	// engine events
	output usb0c_sie_s sie_out
);
	// one-cycle pulses; a STALL decision goes out on the wire next
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sie_out <= '0;
		end else begin
			sie_out <= req_in;
			if (hs_valid_in && hs_in == USB0C_HS_STALL) begin
				sie_out.stall_sent <= 1'h1;
			end
		end
	end
endmodule // usb0c_host

// >>> testbench/tb.sv
`timescale 1ns/100ps
`define CMP(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
$display("BAD %0t got %h want %h", $time, (a), (b)); end end
// ==========================================================
// endpoint zero control register bench
module tb
	import usb0c_pkg::*;
;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, hs_valid, irq;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] req = 8'h00;
	usb0c_sie_s sie;
	usb0c_hs_e hs, last_hs;
	logic [19:0] rows [23];
	int fails = 0, tests_run = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	// latest handshake decision
	always @(posedge clk) if (hs_valid) last_hs <= hs;

	usb0c_ep0 uut (
		.core_clk_in(clk), .rstn_in(rstn),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .sie_ev_in(sie),
		.hs_valid_out(hs_valid), .hs_out(hs), .irq_out(irq)
	);

	usb0c_host host (
		.core_clk_in(clk), .rstn_in(rstn), .req_in(req),
		.hs_valid_in(hs_valid), .hs_in(hs), .sie_out(sie)
	);

	// ==========================================================
	// bus and event tasks; each channel released only when taken
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			resp = bresp;
		end while (!bvalid);
		bready <= 1'h0;
		repeat (3) @(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
			d = rdata;
			resp = rresp;
		end while (!rvalid);
		rready <= 1'h0;
		@(posedge clk);
	endtask

	// six edges cover flag, status and irq latency
	task automatic ev(input logic [7:0] v);
		req <= v;
		@(posedge clk);
		req <= 8'h00;
		repeat (6) @(posedge clk);
	endtask

	task automatic give_verdict;
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================================
	// rows: check hs, hs code, is event, value, expected register
	initial begin
		rows = '{20'h11001, 20'h04000, 20'hb4000, 20'h10100, 20'h00202,
			20'hf4002, 20'h10400, 20'h00202, 20'h18012, 20'h11011,
			20'h00011, 20'h08001, 20'h04000, 20'h02020, 20'hd4004,
			20'h10104, 20'h00404, 20'h00000, 20'h92000, 20'h00808,
			20'hd200c, 20'h10104, 20'h00000};
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		rd(12'h044);
		`CMP({resp, d}, 34'h0)
		foreach (rows[i]) begin
			if (rows[i][16]) ev(rows[i][15:8]);
			else wr(12'h044, rows[i][15:8]);
			rd(12'h044);
			`CMP(d, {24'h0, rows[i][7:0]})
			if (rows[i][19]) `CMP(last_hs, rows[i][18:17])
		end
		// every event kind has left its sticky bit
		rd(12'h080);
		`CMP(d, 32'h1f)
		wr(12'h080, 8'h1f);
		`CMP(resp, 2'h0)
		rd(12'h080);
		`CMP(d, 32'h0)
		wr(12'h084, 8'h01);
		ev(8'h08);
		`CMP(irq, 1'h1)
		wr(12'h084, 8'h00);
		`CMP(irq, 1'h0)
		wr(12'h084, 8'h01);
		wr(12'h080, 8'h01);
		`CMP(irq, 1'h0)
		rd(12'h044);
		`CMP(d, 32'h1)
		// unmapped word is refused both ways
		wr(12'h000, 8'h01);
		`CMP(resp, 2'h2)
		rd(12'h000);
		`CMP({resp, d}, 34'h200000000)
		// a fresh packet raises the line, a mid-run reset drops it
		ev(8'h10);
		`CMP(irq, 1'h1)
		rstn <= 1'h0;
		@(posedge clk);
		`CMP(irq, 1'h0)
		rstn <= 1'h1;
		@(posedge clk);
		rd(12'h044);
		`CMP(d, 32'h0)
		rd(12'h080);
		`CMP(d, 32'h0)
		// IN past the last packet, then a stray OUT in transmit mode
		ev(8'h40);
		wr(12'h044, 8'h08);
		ev(8'h40);
		`CMP(last_hs, USB0C_HS_STALL)
		rd(12'h044);
		`CMP(d, 32'h0c)
		ev(8'h80);
		wr(12'h044, 8'h00);
		rd(12'h044);
		`CMP(d, 32'h0)
		ev(8'h40);
		ev(8'h20);
		rd(12'h044);
		`CMP(d, 32'h10)
		give_verdict;
	end

	// hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict;
	end
endmodule // tb
